// >>> hdl/hvsp_pkg.sv
// constants and types for the high-voltage serial programming link
package hvsp_pkg;

    // clock and link timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int T_SCI_MIN_NS    = 220;
    localparam int T_HVRST_NS      = 100;
    localparam int T_VCC_WAIT_US   = 20;
    localparam int T_HOLD_US       = 10;
    localparam int T_INSTR_WAIT_US = 300;

    // half of the least serial clock period, rounded up
    localparam int SCI_HALF_CYC =
        (T_SCI_MIN_NS * 500 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HVRST_CYC =
        (T_HVRST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int VCC_WAIT_CYC =
        (T_VCC_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC =
        (T_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INSTR_WAIT_CYC =
        (T_INSTR_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OP_BUSY_CYC     = 1000;

    // framing
    localparam int FRAME_BITS      = 11;
    localparam int PAYLOAD_BITS    = 8;
    localparam int PREAMBLE_CLOCKS = 3;

    // memory shape
    localparam int FLASH_WORDS     = 512;
    localparam int PAGE_WORDS      = 16;
    localparam logic [15:0] FLASH_ERASED = 16'hFFFF;

    // entry pattern on data in, instruction in, data out
    localparam logic [2:0] ENTRY_PATTERN = 3'h0;

    // instruction payloads
    localparam logic [7:0] INSTR_CMD     = 8'h4C;
    localparam logic [7:0] INSTR_ADDR_LO = 8'h0C;
    localparam logic [7:0] INSTR_ADDR_HI = 8'h1C;
    localparam logic [7:0] INSTR_DATA_LO = 8'h2C;
    localparam logic [7:0] INSTR_DATA_HI = 8'h3C;
    localparam logic [7:0] INSTR_LATCH   = 8'h7D;
    localparam logic [7:0] INSTR_START   = 8'h64;
    localparam logic [7:0] INSTR_COMMIT  = 8'h6C;
    localparam logic [7:0] INSTR_RD_LO   = 8'h68;
    localparam logic [7:0] INSTR_RD_HI   = 8'h78;
    localparam logic [7:0] INSTR_RD_HI_X = 8'h7C;

    // command payloads carried with INSTR_CMD
    localparam logic [7:0] CMD_ERASE     = 8'h80;
    localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
    localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_ERASE,
        MODE_WR_FLASH,
        MODE_RD_FLASH,
        MODE_WR_EEPROM
    } mode_type;

    function automatic mode_type cmd_mode(input logic [7:0] cmd);
        mode_type m;
        m = MODE_IDLE;
        if (cmd == CMD_ERASE)
            m = MODE_ERASE;
        else if (cmd == CMD_WR_FLASH)
            m = MODE_WR_FLASH;
        else if (cmd == CMD_RD_FLASH)
            m = MODE_RD_FLASH;
        else if (cmd == CMD_WR_EEPROM)
            m = MODE_WR_EEPROM;
        return m;
    endfunction

endpackage

// >>> hdl/hvsp_if.sv
// link wires between the programmer and the programmed device
`timescale 1ns/1ps
interface hvsp_if;
    logic supply_on;
    logic hv_reset_high;
    logic hv_serial_clock;
    logic hv_data_in;
    logic hv_instr_in;
    logic host_sdo_out;
    logic host_sdo_oe_n;
    logic dev_sdo_out;
    logic dev_sdo_oe_n;
    wire  hv_data_out;

    // pulled high when nobody drives
    assign hv_data_out = !dev_sdo_oe_n  ? dev_sdo_out  :
                         !host_sdo_oe_n ? host_sdo_out : 1'b1;

    modport target (
        input  supply_on,
        input  hv_reset_high,
        input  hv_serial_clock,
        input  hv_data_in,
        input  hv_instr_in,
        input  hv_data_out,
        output dev_sdo_out,
        output dev_sdo_oe_n
    );

    modport programmer (
        output supply_on,
        output hv_reset_high,
        output hv_serial_clock,
        output hv_data_in,
        output hv_instr_in,
        input  hv_data_out,
        output host_sdo_out,
        output host_sdo_oe_n
    );
endinterface

// >>> hdl/frame_deserializer.sv
// collects eleven-bit frames from the data and instruction inputs
`timescale 1ns/1ps
module frame_deserializer
    import hvsp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       data_bit,
    input  wire logic       instr_bit,
    output logic            frame_done,
    output logic [7:0]      data_byte,
    output logic [7:0]      instr_byte
);
    logic [3:0] bit_cnt_q;
    logic [9:0] data_sr_q;
    logic [9:0] instr_sr_q;

    // combinational so the last edge of a frame acts at once;
    // the link clock may stop right after it
    assign frame_done = (bit_cnt_q == 4'(FRAME_BITS - 1));
    // zero, payload msb first, two zeros
    assign data_byte  = data_sr_q[8:1];
    assign instr_byte = instr_sr_q[8:1];

    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt_q  <= '0;
            data_sr_q  <= '0;
            instr_sr_q <= '0;
        end else begin
            data_sr_q  <= {data_sr_q[8:0], data_bit};
            instr_sr_q <= {instr_sr_q[8:0], instr_bit};
            bit_cnt_q  <= frame_done ? 4'h0 : bit_cnt_q + 4'h1;
        end
    end
endmodule

// >>> hdl/hvsp_target.sv
// device end: entry latch, frame decode, flash store and busy output
`timescale 1ns/1ps

module hvsp_target
    import hvsp_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   reset,
    hvsp_if.target      link,
    output logic        prog_active,
    output logic        op_busy
);
    // pin vector order: supply, high voltage, data out, instr, data
    localparam int PIN_VCC = 4;
    localparam int PIN_HVR = 3;

    // ---------------- core clock domain ----------------
    logic [4:0]  pin_s1_q;
    logic [4:0]  pin_s2_q;
    logic [4:0]  pin_s3_q;
    logic [4:0]  pin_q;
    logic [2:0]  lnk_s1_q;
    logic [2:0]  lnk_s2_q;
    logic [2:0]  lnk_s3_q;
    logic        link_bit_q;
    logic [4:0]  hv_cnt_q;
    logic        latched_q;
    logic        prog_q;
    logic        busy_q;
    logic        done_q;
    logic [15:0] busy_cnt_q;
    logic        out_q;
    logic        frame_tgl_q;
    logic        op_tgl_q;
    logic [7:0]  out_sr_q;
    wire         rd_bit = out_sr_q[7];

    wire [4:0] pin_raw = {link.supply_on, link.hv_reset_high,
                          link.hv_data_out, link.hv_instr_in,
                          link.hv_data_in};
    wire hv_on    = pin_q[PIN_VCC] & pin_q[PIN_HVR];
    wire hv_met   = (hv_cnt_q == 5'(HVRST_CYC - 1));
    wire frame_ev = lnk_s2_q[0] ^ lnk_s3_q[0];
    wire op_ev    = lnk_s2_q[1] ^ lnk_s3_q[1];
    wire busy_end = (busy_cnt_q == 16'(OP_BUSY_CYC - 1));

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_q    <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= (pin_s2_q & pin_s3_q)
                      | (pin_q & (pin_s2_q | pin_s3_q));
        end
    end

    // entry: pattern sampled once high voltage has stood long enough
    always_ff @(posedge core_clk) begin
        if (reset || !hv_on) begin
            hv_cnt_q  <= '0;
            latched_q <= 1'b0;
            prog_q    <= 1'b0;
        end else if (!latched_q) begin
            hv_cnt_q <= hv_cnt_q + 5'h1;
            if (hv_met) begin
                latched_q <= 1'b1;
                prog_q    <= (pin_q[2:0] == ENTRY_PATTERN);
            end
        end
    end

    // frame toggle, operation toggle and read bit from the link side
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lnk_s1_q   <= '0;
            lnk_s2_q   <= '0;
            lnk_s3_q   <= '0;
            link_bit_q <= 1'b0;
        end else begin
            lnk_s1_q   <= {rd_bit, op_tgl_q, frame_tgl_q};
            lnk_s2_q   <= lnk_s1_q;
            lnk_s3_q   <= lnk_s2_q;
            if (lnk_s2_q[2] == lnk_s3_q[2])
                link_bit_q <= lnk_s3_q[2];
        end
    end

    // busy timer; done holds data out high until the next frame
    always_ff @(posedge core_clk) begin
        if (reset || !prog_q) begin
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            busy_cnt_q <= '0;
        end else if (op_ev) begin
            busy_q     <= 1'b1;
            done_q     <= 1'b0;
            busy_cnt_q <= '0;
        end else if (frame_ev) begin
            done_q <= 1'b0;
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q + 16'h1;
            if (busy_end) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset)
            out_q <= 1'b0;
        else
            out_q <= !busy_q && (done_q || link_bit_q);
    end

    // pin released until the latched pattern matches the entry pattern
    assign link.dev_sdo_oe_n = !prog_q;
    assign link.dev_sdo_out  = out_q;
    assign prog_active       = prog_q;
    assign op_busy           = busy_q;

    // ---------------- link clock domain ----------------
    // no edges arrive between frames; held in reset until the
    // programmer's preamble clocks carry the mode flag across
    logic        pm_s1_q;
    logic        pm_s2_q;
    logic        pm_s3_q;
    mode_type    mode_q;
    logic        armed_q;
    logic        rd_shift_q;
    logic [7:0]  addr_lo_q;
    logic        addr_hi_q;
    logic [7:0]  data_lo_q;
    logic [7:0]  data_hi_q;
    logic [15:0] page_buf [PAGE_WORDS];
    logic [15:0] flash [FLASH_WORDS];
    logic        f_done;
    logic [7:0]  f_data;
    logic [7:0]  f_instr;

    wire link_rst = !pm_s3_q;

    frame_deserializer i_frame_deserializer (
        .clk        (link.hv_serial_clock),
        .rst        (link_rst),
        .data_bit   (link.hv_data_in),
        .instr_bit  (link.hv_instr_in),
        .frame_done (f_done),
        .data_byte  (f_data),
        .instr_byte (f_instr)
    );

    wire is_cmd    = f_done && (f_instr == INSTR_CMD);
    wire is_commit = f_done && (f_instr == INSTR_COMMIT) && armed_q;
    wire do_erase  = is_commit && (mode_q == MODE_ERASE);
    wire do_prog   = is_commit && (mode_q == MODE_WR_FLASH);
    wire do_latch  = f_done && (f_instr == INSTR_LATCH)
                  && (mode_q == MODE_WR_FLASH);
    wire rd_mode   = (mode_q == MODE_RD_FLASH);
    wire prep_lo   = f_done && (f_instr == INSTR_RD_LO) && rd_mode;
    wire prep_hi   = f_done && (f_instr == INSTR_RD_HI) && rd_mode;
    wire [8:0]  word_addr = {addr_hi_q, addr_lo_q};
    wire [15:0] rd_word   = flash[word_addr];
    wire [4:0]  page_base = {addr_hi_q, addr_lo_q[7:4]};

    // raised at once on exit, released on the third link edge;
    // the link clock is stopped while the mode flag is low
    always_ff @(posedge link.hv_serial_clock or negedge prog_q) begin
        if (!prog_q) begin
            pm_s1_q <= 1'b0;
            pm_s2_q <= 1'b0;
            pm_s3_q <= 1'b0;
        end else begin
            pm_s1_q <= 1'b1;
            pm_s2_q <= pm_s1_q;
            pm_s3_q <= pm_s2_q;
        end
    end

    // mode and address registers
    always_ff @(posedge link.hv_serial_clock) begin
        if (link_rst) begin
            mode_q    <= MODE_IDLE;
            armed_q   <= 1'b0;
            addr_lo_q <= '0;
            addr_hi_q <= 1'b0;
            data_lo_q <= '0;
            data_hi_q <= '0;
        end else if (f_done) begin
            if (is_cmd)
                mode_q <= cmd_mode(f_data);
            armed_q <= (f_instr == INSTR_START);
            if (f_instr == INSTR_ADDR_LO)
                addr_lo_q <= f_data;
            if (f_instr == INSTR_ADDR_HI)
                addr_hi_q <= f_data[0];
            if (f_instr == INSTR_DATA_LO)
                data_lo_q <= f_data;
            if (f_instr == INSTR_DATA_HI)
                data_hi_q <= f_data;
        end
    end

    // read shifter: byte appears at prepare, shifts on the next frame
    always_ff @(posedge link.hv_serial_clock) begin
        if (link_rst) begin
            out_sr_q   <= '0;
            rd_shift_q <= 1'b0;
        end else if (prep_lo || prep_hi) begin
            out_sr_q   <= prep_hi ? rd_word[15:8] : rd_word[7:0];
            rd_shift_q <= 1'b1;
        end else if (is_commit) begin
            out_sr_q   <= '0;
            rd_shift_q <= 1'b0;
        end else begin
            if (rd_shift_q)
                out_sr_q <= {out_sr_q[6:0], 1'b0};
            if (f_done)
                rd_shift_q <= 1'b0;
        end
    end

    // toggles carry frame ends and operation starts to the core side;
    // cleared at exit, so a new session brings no false edge across
    always_ff @(posedge link.hv_serial_clock or negedge prog_q) begin
        if (!prog_q) begin
            frame_tgl_q <= 1'b0;
            op_tgl_q    <= 1'b0;
        end else if (!link_rst) begin
            if (f_done)
                frame_tgl_q <= !frame_tgl_q;
            if (do_erase || do_prog)
                op_tgl_q <= !op_tgl_q;
        end
    end

    // storage has no reset; contents survive mode changes
    always_ff @(posedge link.hv_serial_clock) begin
        if (do_latch)
            page_buf[addr_lo_q[3:0]] <= {data_hi_q, data_lo_q};
        if (do_erase) begin
            for (int i = 0; i < FLASH_WORDS; i++)
                flash[i] <= FLASH_ERASED;
        end else if (do_prog) begin
            for (int i = 0; i < PAGE_WORDS; i++)
                flash[{page_base, 4'(i)}] <= page_buf[i];
        end
    end
endmodule

// >>> hdl/hvsp_programmer.sv
// programmer end: entry sequence, serial clock and frame transfer
`timescale 1ns/1ps
module hvsp_programmer
    import hvsp_pkg::*;
#(
    parameter int VCC_WAIT   = VCC_WAIT_CYC,
    parameter int INSTR_WAIT = INSTR_WAIT_CYC
)(
    input  wire logic       core_clk,
    input  wire logic       reset,
    hvsp_if.programmer      link,
    input  wire logic       session_req,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic [7:0] cmd_data,
    input  wire logic [7:0] cmd_instr,
    input  wire logic       cmd_wait,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data
);
    typedef enum logic [3:0] {
        H_OFF, H_POWER, H_HV, H_SETTLE,
        H_LOW, H_HIGH, H_IDLE, H_POLL
    } host_state_type;

    host_state_type state_q;
    logic [16:0] cnt_q;
    logic [3:0]  bit_q;
    logic        pre_q;
    logic        wait_q;
    logic        sci_q;
    logic [10:0] dsr_q;
    logic [10:0] isr_q;
    logic [7:0]  rx_q;
    logic        rsp_valid_q;
    logic [7:0]  rsp_data_q;
    logic        sdo_s1_q;
    logic        sdo_s2_q;
    logic        sdo_s3_q;
    logic        sdo_q;

    wire hold_end   = (cnt_q == 17'(HOLD_CYC - 1));
    wire vcc_end    = (cnt_q == 17'(VCC_WAIT - 1));
    wire settle_end = (cnt_q == 17'(INSTR_WAIT - 1));
    wire half_end   = (cnt_q == 17'(SCI_HALF_CYC - 1));
    wire [3:0] last = pre_q ? 4'(PREAMBLE_CLOCKS - 1)
                            : 4'(FRAME_BITS - 1);
    wire bit_last   = (bit_q == last);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sdo_s1_q <= 1'b0;
            sdo_s2_q <= 1'b0;
            sdo_s3_q <= 1'b0;
            sdo_q    <= 1'b0;
        end else begin
            sdo_s1_q <= link.hv_data_out;
            sdo_s2_q <= sdo_s1_q;
            sdo_s3_q <= sdo_s2_q;
            if (sdo_s2_q == sdo_s3_q)
                sdo_q <= sdo_s3_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= H_OFF;
            cnt_q   <= '0;
            bit_q   <= '0;
            pre_q   <= 1'b0;
            wait_q  <= 1'b0;
            sci_q   <= 1'b0;
            dsr_q   <= '0;
            isr_q   <= '0;
            rx_q    <= '0;
        end else begin
            cnt_q <= cnt_q + 17'h1;
            unique case (state_q)
                H_OFF: begin
                    if (!session_req)
                        cnt_q <= '0;
                    else if (hold_end) begin
                        state_q <= H_POWER;
                        cnt_q   <= '0;
                    end
                end
                H_POWER: if (vcc_end) begin
                    state_q <= H_HV;
                    cnt_q   <= '0;
                end
                H_HV: if (hold_end) begin
                    state_q <= H_SETTLE;
                    cnt_q   <= '0;
                end
                H_SETTLE: if (settle_end) begin
                    state_q <= H_LOW;
                    cnt_q   <= '0;
                    bit_q   <= '0;
                    pre_q   <= 1'b1;
                    dsr_q   <= '0;
                    isr_q   <= '0;
                end
                H_LOW: if (half_end) begin
                    state_q <= H_HIGH;
                    cnt_q   <= '0;
                    sci_q   <= 1'b1;
                    if (bit_q < 4'(PAYLOAD_BITS))
                        rx_q <= {rx_q[6:0], sdo_q};
                end
                H_HIGH: if (half_end) begin
                    cnt_q <= '0;
                    sci_q <= 1'b0;
                    dsr_q <= {dsr_q[9:0], 1'b0};
                    isr_q <= {isr_q[9:0], 1'b0};
                    bit_q <= bit_q + 4'h1;
                    if (!bit_last)
                        state_q <= H_LOW;
                    else if (wait_q && !pre_q)
                        state_q <= H_POLL;
                    else
                        state_q <= H_IDLE;
                end
                H_IDLE: begin
                    if (!session_req)
                        state_q <= H_OFF;
                    else if (cmd_valid) begin
                        state_q <= H_LOW;
                        cnt_q   <= '0;
                        bit_q   <= '0;
                        pre_q   <= 1'b0;
                        wait_q  <= cmd_wait;
                        dsr_q   <= {1'b0, cmd_data, 2'b00};
                        isr_q   <= {1'b0, cmd_instr, 2'b00};
                    end
                end
                H_POLL: begin
                    if (!session_req)
                        state_q <= H_OFF;
                    else if (sdo_q)
                        state_q <= H_IDLE;
                end
            endcase
        end
    end

    wire frame_end = (state_q == H_HIGH) && half_end && bit_last
                  && !pre_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= '0;
        end else begin
            rsp_valid_q <= frame_end;
            if (frame_end)
                rsp_data_q <= rx_q;
        end
    end

    assign link.supply_on       = (state_q != H_OFF);
    assign link.hv_reset_high   = (state_q != H_OFF)
                               && (state_q != H_POWER);
    // data out pin driven low from the session request until the high voltage hold time ends
    assign link.host_sdo_oe_n   = !((state_q == H_OFF && session_req)
                               || state_q == H_POWER
                               || state_q == H_HV);
    assign link.host_sdo_out    = 1'b0;
    assign link.hv_serial_clock = sci_q;
    assign link.hv_data_in      = dsr_q[10];
    assign link.hv_instr_in     = isr_q[10];
    assign cmd_ready            = (state_q == H_IDLE) && session_req;
    assign rsp_valid            = rsp_valid_q;
    assign rsp_data             = rsp_data_q;
endmodule

// >>> sim/hvsp_properties.sv
// concurrent checks on the programming link wires
`timescale 1ns/1ps
module hvsp_properties
    import hvsp_pkg::*;
#(
    parameter int VCC_WAIT   = VCC_WAIT_CYC,
    parameter int INSTR_WAIT = INSTR_WAIT_CYC
)(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_on,
    input wire logic hv_reset_high,
    input wire logic hv_serial_clock,
    input wire logic hv_data_in,
    input wire logic hv_instr_in,
    input wire logic host_sdo_oe_n,
    input wire logic dev_sdo_oe_n,
    input wire logic hv_data_out
);
    int          hv_cnt;
    int          sup_cnt;
    logic [15:0] sci_cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // phase counters; delays here exceed what a plain delay may span
    always_ff @(posedge core_clk) begin
        hv_cnt  <= (reset || !hv_reset_high) ? 0 : hv_cnt + 1;
        sup_cnt <= (reset || !supply_on) ? 0 : sup_cnt + 1;
    end

    always_ff @(posedge core_clk) begin
        if (reset || $changed(hv_serial_clock))
            sci_cnt <= 16'h0000;
        else if (sci_cnt != 16'hFFFF)
            sci_cnt <= sci_cnt + 16'h0001;
    end

    AST_SCI_HALF: assert property (
        $changed(hv_serial_clock) |-> sci_cnt >= SCI_HALF_CYC - 1)
        else $error("serial clock half period too short");
    AST_IDLE_PATTERN: assert property (
        $rose(supply_on) |-> !hv_reset_high && !hv_data_in
            && !hv_instr_in && !hv_data_out)
        else $error("pins not idle at power up");
    AST_HV_AFTER_SUPPLY: assert property (
        $rose(hv_reset_high) |-> sup_cnt >= VCC_WAIT - 1
            && sup_cnt <= VCC_WAIT + 1)
        else $error("high voltage at wrong time");
    AST_PATTERN_HELD: assert property (
        hv_reset_high && hv_cnt < HOLD_CYC - 2 |-> $stable(hv_data_in)
            && $stable(hv_instr_in) && !host_sdo_oe_n)
        else $error("entry pattern changed too early");
    AST_HOST_RELEASE: assert property (
        hv_cnt > HOLD_CYC + 2 |-> host_sdo_oe_n)
        else $error("host still drives data out");
    AST_INSTR_WAIT: assert property (
        $rose(hv_serial_clock) |-> hv_cnt >= HOLD_CYC + INSTR_WAIT)
        else $error("serial clock too soon after entry");
    AST_EXIT: assert property (
        $fell(hv_reset_high) |-> ##[1:8] dev_sdo_oe_n)
        else $error("device kept driving after exit");
    AST_LATCH_MIN: assert property (
        $rose(hv_reset_high) |-> dev_sdo_oe_n [*8])
        else $error("pattern latched too early");
    AST_LATCH_DONE: assert property (
        $rose(hv_reset_high) && supply_on && !hv_data_in && !hv_instr_in
            && !hv_data_out |-> ##[20:40] !dev_sdo_oe_n)
        else $error("pattern not latched");
    AST_FRAME_EDGE: assert property (
        $changed(hv_data_in) || $changed(hv_instr_in) |-> !hv_serial_clock)
        else $error("frame bit changed while clock high");
endmodule

// >>> sim/high_voltage_serial_programming_test.sv
// self-checking bench: programmer end driving the device end
`timescale 1ns/1ps
module high_voltage_serial_programming_test
    import hvsp_pkg::*;
;
    typedef struct packed {
        logic [7:0] d;
        logic [7:0] i;
        logic       w;
        logic       c;
        logic [7:0] e;
    } row_type;

    // payload, instruction, poll, compare, expected read byte
    row_type rows [28] = '{
        '{8'h80,8'h4C,1'b0,1'b0,8'h00}, '{8'h00,8'h64,1'b0,1'b0,8'h00},
        '{8'h00,8'h6C,1'b1,1'b0,8'h00}, '{8'h02,8'h4C,1'b0,1'b0,8'h00},
        '{8'h25,8'h0C,1'b0,1'b0,8'h00}, '{8'h00,8'h1C,1'b0,1'b0,8'h00},
        '{8'h00,8'h68,1'b0,1'b0,8'h00}, '{8'h00,8'h6C,1'b0,1'b1,8'hFF},
        '{8'h00,8'h78,1'b0,1'b0,8'h00}, '{8'h00,8'h7C,1'b0,1'b1,8'hFF},
        '{8'h10,8'h4C,1'b0,1'b0,8'h00}, '{8'h25,8'h0C,1'b0,1'b0,8'h00},
        '{8'hA5,8'h2C,1'b0,1'b0,8'h00}, '{8'h3C,8'h3C,1'b0,1'b0,8'h00},
        '{8'h00,8'h7D,1'b0,1'b0,8'h00}, '{8'h00,8'h1C,1'b0,1'b0,8'h00},
        '{8'h00,8'h64,1'b0,1'b0,8'h00}, '{8'h00,8'h6C,1'b1,1'b0,8'h00},
        '{8'h02,8'h4C,1'b0,1'b0,8'h00}, '{8'h25,8'h0C,1'b0,1'b0,8'h00},
        '{8'h00,8'h1C,1'b0,1'b0,8'h00}, '{8'h00,8'h68,1'b0,1'b0,8'h00},
        '{8'h00,8'h6C,1'b0,1'b1,8'hA5}, '{8'h00,8'h78,1'b0,1'b0,8'h00},
        '{8'h00,8'h7C,1'b0,1'b1,8'h3C}, '{8'h11,8'h4C,1'b0,1'b0,8'h00},
        '{8'h00,8'h68,1'b0,1'b0,8'h00}, '{8'h00,8'h6C,1'b0,1'b1,8'h00}
    };

    logic       core_clk    = 1'b0;
    logic       reset       = 1'b1;
    logic       session_req = 1'b0;
    logic       cmd_valid   = 1'b0;
    logic [7:0] cmd_data    = 8'h00;
    logic [7:0] cmd_instr   = 8'h00;
    logic       cmd_wait    = 1'b0;
    logic       cmd_ready;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       prog_active;
    logic       op_busy;
    int         error_cnt   = 0;
    int         tests_run   = 0;

    always #2 core_clk = ~core_clk;

    hvsp_if link_bus ();

    hvsp_target i_hvsp_target (
        .core_clk    (core_clk),
        .reset       (reset),
        .link        (link_bus.target),
        .prog_active (prog_active),
        .op_busy     (op_busy)
    );

    // short waits keep the entry phase to a few thousand cycles
    hvsp_programmer #(.VCC_WAIT(40), .INSTR_WAIT(60)) i_hvsp_programmer (
        .core_clk    (core_clk),
        .reset       (reset),
        .link        (link_bus.programmer),
        .session_req (session_req),
        .cmd_valid   (cmd_valid),
        .cmd_ready   (cmd_ready),
        .cmd_data    (cmd_data),
        .cmd_instr   (cmd_instr),
        .cmd_wait    (cmd_wait),
        .rsp_valid   (rsp_valid),
        .rsp_data    (rsp_data)
    );

    hvsp_properties #(.VCC_WAIT(40), .INSTR_WAIT(60)) i_hvsp_properties (
        .core_clk        (core_clk),
        .reset           (reset),
        .supply_on       (link_bus.supply_on),
        .hv_reset_high   (link_bus.hv_reset_high),
        .hv_serial_clock (link_bus.hv_serial_clock),
        .hv_data_in      (link_bus.hv_data_in),
        .hv_instr_in     (link_bus.hv_instr_in),
        .host_sdo_oe_n   (link_bus.host_sdo_oe_n),
        .dev_sdo_oe_n    (link_bus.dev_sdo_oe_n),
        .hv_data_out     (link_bus.hv_data_out)
    );

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic send(input row_type r);
        int n;
        @(negedge core_clk);
        cmd_data  = r.d;
        cmd_instr = r.i;
        cmd_wait  = r.w;
        cmd_valid = 1'b1;
        for (n = 0; cmd_ready !== 1'b1 && n < 3000; n++)
            @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (n = 0; rsp_valid !== 1'b1 && n < 800; n++)
            @(negedge core_clk);
        chk(n < 800, "no frame answer");
        if (r.c)
            chk(rsp_data === r.e, "read byte wrong");
        if (r.w) begin
            repeat (60) @(negedge core_clk);
            chk(op_busy && !link_bus.hv_data_out, "not busy");
            for (n = 0; cmd_ready !== 1'b1 && n < 3000; n++)
                @(negedge core_clk);
            chk(n > OP_BUSY_CYC - 100 && n < 3000, "busy span off");
        end
    endtask

    initial begin : main_seq
        int n;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(prog_active === 1'b0 && cmd_ready === 1'b0, "reset state");
        reset       = 1'b0;
        session_req = 1'b1;
        for (n = 0; prog_active !== 1'b1 && n < 4000; n++)
            @(negedge core_clk);
        chk(link_bus.dev_sdo_oe_n === 1'b0, "no entry");
        for (n = 0; cmd_ready !== 1'b1 && n < 4000; n++)
            @(negedge core_clk);
        chk(link_bus.host_sdo_oe_n === 1'b1, "host drives");
        foreach (rows[k])
            send(rows[k]);
        @(negedge core_clk);
        session_req = 1'b0;
        repeat (20) @(negedge core_clk);
        chk(!prog_active && link_bus.dev_sdo_oe_n, "stuck");
        // re-entry: the link side must start clean again
        session_req = 1'b1;
        for (n = 0; cmd_ready !== 1'b1 && n < 9000; n++)
            @(negedge core_clk);
        chk(n < 9000, "no re-entry");
        for (int k = 18; k < 23; k++)
            send(rows[k]);
        give_verdict();
    end

    // whole run needs about 140 us
    initial begin
        #300000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule
